// ### src/rcs_decoder.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rcs_decoder (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    // register port
    input  wire logic [7:0]                   regAddr,
    input  wire logic [31:0]                  regWdata,
    input  wire logic                         regWr,
    input  wire logic                         regRd,
    output logic      [31:0]                  regRdata,
    // terminal pins
    input  wire logic [rcs_pkg::NUM_TERM-1:0] termIn,
    // drive command
    output logic                              runCmd,
    output logic                              revCmd,
    // serial link settings
    output logic      [7:0]                   stationId,
    output logic      [1:0]                   protocolSel,
    output logic      [2:0]                   baudSel,
    output logic      [1:0]                   frameFormat
);
    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    logic [2:0]  cmdSource_reg;
    logic [13:0] runDelay_reg;
    logic [5:0]  termFunc_reg [rcs_pkg::NUM_TERM];
    logic [1:0]  serCmd_reg;
    logic [rcs_pkg::NUM_TERM-1:0] termSync;
    rcs_pkg::rcs_state_t state_reg;

    rcs_sync rcs_sync_i (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .asyncIn (termIn),
        .syncOut (termSync)
    );

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cmdSource_reg <= rcs_pkg::SRC_KEYPAD;
        end else if (regWr && regAddr == rcs_pkg::ADDR_SOURCE && regWdata[2:0] <= rcs_pkg::SRC_MAX) begin
            cmdSource_reg <= regWdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            runDelay_reg <= rcs_pkg::DELAY_RST;
        end else if (regWr && regAddr == rcs_pkg::ADDR_DELAY && regWdata[13:0] <= rcs_pkg::DELAY_MAX) begin
            runDelay_reg <= regWdata[13:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stationId <= rcs_pkg::STATION_RST;
        end else if (regWr && regAddr == rcs_pkg::ADDR_STATION && regWdata[31:8] == 24'h000000
                     && regWdata[7:0] >= rcs_pkg::STATION_MIN && regWdata[7:0] <= rcs_pkg::STATION_MAX) begin
            stationId <= regWdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            protocolSel <= rcs_pkg::PROTO_RST;
            baudSel     <= rcs_pkg::BAUD_RST;
            frameFormat <= rcs_pkg::FRAME_RST;
        end else if (regWr) begin
            if (regAddr == rcs_pkg::ADDR_PROTO) begin
                protocolSel <= regWdata[1:0];
            end
            if (regAddr == rcs_pkg::ADDR_BAUD && regWdata[2:0] <= rcs_pkg::BAUD_MAX) begin
                baudSel <= regWdata[2:0];
            end
            if (regAddr == rcs_pkg::ADDR_FRAME) begin
                frameFormat <= regWdata[1:0];
            end
        end
    end

    // run/reverse word written by the host-side message handler
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            serCmd_reg <= 2'h0;
        end else if (regWr && regAddr == rcs_pkg::ADDR_SERCMD) begin
            serCmd_reg <= regWdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // per-terminal function select and decode
    // ------------------------------------------------------------
    logic [rcs_pkg::NUM_TERM-1:0] isFwd;
    logic [rcs_pkg::NUM_TERM-1:0] isRev;

    genvar gi;
    generate
        for (gi = 0; gi < rcs_pkg::NUM_TERM; gi++) begin : g_term
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    termFunc_reg[gi] <= 6'h00;
                end else if (regWr && regAddr == rcs_pkg::ADDR_FUNC0 + 8'(4 * gi)
                             && regWdata[5:0] <= rcs_pkg::FUNC_MAX) begin
                    termFunc_reg[gi] <= regWdata[5:0];
                end
            end
            assign isFwd[gi] = termSync[gi] && termFunc_reg[gi] == rcs_pkg::FUNC_FWD;
            assign isRev[gi] = termSync[gi] && termFunc_reg[gi] == rcs_pkg::FUNC_REV;
        end
    endgenerate

    logic fwdIn;
    logic revIn;
    assign fwdIn = |isFwd;
    assign revIn = |isRev;

    // ------------------------------------------------------------
    // terminal request
    // ------------------------------------------------------------
    logic termRun;
    logic termRev;
    logic termScheme;

    always_comb begin
        termRun = 1'b0;
        termRev = 1'b0;
        case (cmdSource_reg)
            rcs_pkg::SRC_TWO_TERM: begin
                termRun = fwdIn ^ revIn;
                termRev = revIn;
            end
            rcs_pkg::SRC_RUN_DIR: begin
                termRun = fwdIn;
                termRev = revIn;
            end
            default: begin
                termRun = 1'b0;
                termRev = 1'b0;
            end
        endcase
    end
    assign termScheme = cmdSource_reg == rcs_pkg::SRC_TWO_TERM || cmdSource_reg == rcs_pkg::SRC_RUN_DIR;

    // ------------------------------------------------------------
    // run-on delay: 10 ms ticks, setting in hundredths of a second
    // ------------------------------------------------------------
    logic [rcs_pkg::TICK_W-1:0] tickCnt_reg;
    logic [13:0] delayCnt_reg;
    logic        tick;
    // 10 ms granularity keeps the counter short; a running delay is cut back to stop when termRun drops
    assign tick = tickCnt_reg == rcs_pkg::TICK_W'(rcs_pkg::TICK_CYCLES - 1);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tickCnt_reg <= '0;
        end else if (state_reg != rcs_pkg::ST_DELAY || tick) begin
            tickCnt_reg <= '0;
        end else begin
            tickCnt_reg <= tickCnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= rcs_pkg::ST_STOP;
            delayCnt_reg <= 14'h0000;
        end else begin
            case (state_reg)
                rcs_pkg::ST_STOP: begin
                    delayCnt_reg <= 14'h0000;
                    if (termRun) begin
                        state_reg <= (runDelay_reg == 14'h0000) ? rcs_pkg::ST_RUN : rcs_pkg::ST_DELAY;
                    end
                end
                rcs_pkg::ST_DELAY: begin
                    if (!termRun) begin
                        state_reg <= rcs_pkg::ST_STOP;
                    end else if (tick) begin
                        delayCnt_reg <= delayCnt_reg + 14'h0001;
                        if (delayCnt_reg + 14'h0001 >= runDelay_reg) begin
                            state_reg <= rcs_pkg::ST_RUN;
                        end
                    end
                end
                rcs_pkg::ST_RUN: begin
                    if (!termRun) begin
                        state_reg <= rcs_pkg::ST_STOP;
                    end
                end
                default: state_reg <= rcs_pkg::ST_STOP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // command outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            runCmd <= 1'b0;
            revCmd <= 1'b0;
        end else if (cmdSource_reg == rcs_pkg::SRC_SERIAL) begin
            runCmd <= serCmd_reg[0];
            revCmd <= serCmd_reg[1];
        end else if (termScheme) begin
            runCmd <= termRun && state_reg == rcs_pkg::ST_RUN;
            revCmd <= termRev;
        end else begin
            runCmd <= 1'b0;
            revCmd <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    logic [31:0] rdNext;
    always_comb begin
        rdNext = 32'h00000000;
        case (regAddr)
            rcs_pkg::ADDR_SOURCE:  rdNext = {29'h0, cmdSource_reg};
            rcs_pkg::ADDR_DELAY:   rdNext = {18'h0, runDelay_reg};
            rcs_pkg::ADDR_STATION: rdNext = {24'h0, stationId};
            rcs_pkg::ADDR_PROTO:   rdNext = {30'h0, protocolSel};
            rcs_pkg::ADDR_BAUD:    rdNext = {29'h0, baudSel};
            rcs_pkg::ADDR_FRAME:   rdNext = {30'h0, frameFormat};
            rcs_pkg::ADDR_SERCMD:  rdNext = {30'h0, serCmd_reg};
            rcs_pkg::ADDR_STATUS:  rdNext = {19'h0, termSync, state_reg};
            default: begin
                for (int i = 0; i < rcs_pkg::NUM_TERM; i++) begin
                    if (regAddr == rcs_pkg::ADDR_FUNC0 + 8'(4 * i)) begin
                        rdNext = {26'h0, termFunc_reg[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 32'h00000000;
        end else begin
            regRdata <= regRd ? rdNext : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    stop_when_equal_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmdSource_reg == rcs_pkg::SRC_TWO_TERM && fwdIn == revIn) |=> !runCmd)
        else $error("run while both terminals equal");
    ignore_terms_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!termScheme && cmdSource_reg != rcs_pkg::SRC_SERIAL) |=> !runCmd && !revCmd)
        else $error("terminal command leaked");
    delay_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state_reg == rcs_pkg::ST_STOP && $rose(termRun) && runDelay_reg != 14'h0000)
        |=> state_reg == rcs_pkg::ST_DELAY)
        else $error("run started without delay");
    rev_direction_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmdSource_reg == rcs_pkg::SRC_RUN_DIR && revIn) |=> revCmd)
        else $error("reverse not followed");
    serial_cmd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmdSource_reg == rcs_pkg::SRC_SERIAL) |=> runCmd == $past(serCmd_reg[0]))
        else $error("serial run mismatch");
    station_range_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        stationId >= rcs_pkg::STATION_MIN && stationId <= rcs_pkg::STATION_MAX)
        else $error("station id out of range");
    baud_range_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        baudSel <= rcs_pkg::BAUD_MAX)
        else $error("baud select out of range");
    func_range_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        termFunc_reg[0] <= rcs_pkg::FUNC_MAX)
        else $error("function select out of range");
    two_term_run_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmdSource_reg == rcs_pkg::SRC_TWO_TERM && fwdIn && !revIn && state_reg == rcs_pkg::ST_RUN) |=> runCmd)
        else $error("single terminal did not run");
    run_input_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmdSource_reg == rcs_pkg::SRC_RUN_DIR && !fwdIn) |=> !runCmd)
        else $error("run without run input");
    fwd_direction_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmdSource_reg == rcs_pkg::SRC_RUN_DIR && !revIn) |=> !revCmd)
        else $error("forward not followed");
    zero_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state_reg == rcs_pkg::ST_STOP && termRun && runDelay_reg == 14'h0000) |=> state_reg == rcs_pkg::ST_RUN)
        else $error("zero delay did not start");
    delay_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == rcs_pkg::ST_DELAY |-> !runCmd)
        else $error("run during delay");
endmodule // rcs_decoder
`default_nettype wire

// ### src/rcs_pkg.sv
`default_nettype none
package rcs_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 20000000;
    localparam int unsigned DELAY_TICK_MS = 10;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * DELAY_TICK_MS;
    localparam int unsigned TICK_W        = 18;

    // ------------------------------------------------------------
    // register map (word index = byte address / 4)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SOURCE   = 8'h00;
    localparam logic [7:0] ADDR_DELAY    = 8'h04;
    localparam logic [7:0] ADDR_STATION  = 8'h08;
    localparam logic [7:0] ADDR_PROTO    = 8'h0C;
    localparam logic [7:0] ADDR_BAUD     = 8'h10;
    localparam logic [7:0] ADDR_FRAME    = 8'h14;
    localparam logic [7:0] ADDR_SERCMD   = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_FUNC0    = 8'h20;

    // ------------------------------------------------------------
    // settings, ranges, reset values
    // ------------------------------------------------------------
    localparam int unsigned NUM_TERM   = 11;
    localparam logic [2:0] SRC_KEYPAD  = 3'h0;
    localparam logic [2:0] SRC_TWO_TERM = 3'h1;
    localparam logic [2:0] SRC_RUN_DIR = 3'h2;
    localparam logic [2:0] SRC_SERIAL  = 3'h3;
    localparam logic [2:0] SRC_MAX     = 3'h5;
    localparam logic [5:0] FUNC_FWD    = 6'h01;
    localparam logic [5:0] FUNC_REV    = 6'h02;
    localparam logic [5:0] FUNC_MAX    = 6'h33;
    localparam logic [13:0] DELAY_RST  = 14'h0064;
    localparam logic [13:0] DELAY_MAX  = 14'h2710;
    localparam logic [7:0] STATION_RST = 8'h01;
    localparam logic [7:0] STATION_MIN = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'hFA;
    localparam logic [1:0] PROTO_RST   = 2'h0;
    localparam logic [2:0] BAUD_RST    = 3'h3;
    localparam logic [2:0] BAUD_MAX    = 3'h5;
    localparam logic [1:0] FRAME_RST   = 2'h0;

    typedef enum logic [1:0] {
        ST_STOP  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b11
    } rcs_state_t;
endpackage
`default_nettype wire

// ### src/rcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_sync (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    // levels
    input  wire logic [rcs_pkg::NUM_TERM-1:0] asyncIn,
    output logic      [rcs_pkg::NUM_TERM-1:0] syncOut
);
    logic [rcs_pkg::NUM_TERM-1:0] stage1_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule // rcs_sync
`default_nettype wire

// ### verif/rcs_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_contacts #(
    parameter int FWD_POS = 3,
    parameter int REV_POS = 9
) (
    // clock
    input  wire logic                         ref_clk,
    // contact closures asked for by the bench
    input  wire logic                         fwdReq,
    input  wire logic                         revReq,
    // terminal levels
    output logic      [rcs_pkg::NUM_TERM-1:0] termIn
);
    // ------------------------------------------------------------
    // contacts
    // ------------------------------------------------------------
    // open contacts read low, as with pull-downs on the inputs
    initial termIn = '0;
    always @(posedge ref_clk) begin
        for (int i = 0; i < rcs_pkg::NUM_TERM; i++) begin
            termIn[i] <= (i == FWD_POS) ? fwdReq : (i == REV_POS) ? revReq : 1'b0;
        end
    end
endmodule // rcs_contacts
`default_nettype wire

// ### verif/rcs_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_decoder_test;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                         ref_clk;
    logic                         nrst;
    logic [7:0]                   regAddr;
    logic [31:0]                  regWdata;
    logic                         regWr;
    logic                         regRd;
    logic [31:0]                  regRdata;
    logic [rcs_pkg::NUM_TERM-1:0] termIn;
    logic                         runCmd;
    logic                         revCmd;
    logic [7:0]                   stationId;
    logic [1:0]                   protocolSel;
    logic [2:0]                   baudSel;
    logic [1:0]                   frameFormat;
    logic                         fwdReq;
    logic                         revReq;
    int                           failCount;
    int                           compares;
    int                           cycles;
    // forward on terminal 3, reverse on optional terminal 9
    localparam logic [7:0] FWD_FN = rcs_pkg::ADDR_FUNC0 + 8'h0C;
    localparam logic [7:0] REV_FN = rcs_pkg::ADDR_FUNC0 + 8'h24;

    rcs_decoder rcs_decoder_i (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .termIn(termIn), .runCmd(runCmd),
        .revCmd(revCmd), .stationId(stationId), .protocolSel(protocolSel), .baudSel(baudSel),
        .frameFormat(frameFormat));
    rcs_contacts #(.FWD_POS(3), .REV_POS(9)) rcs_contacts_i (.ref_clk(ref_clk), .fwdReq(fwdReq),
        .revReq(revReq), .termIn(termIn));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic results();
        if (failCount == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        compares++;
        if (act !== exp) begin
            failCount++;
            $display("wrong value at %0t ns: got %0h expected %0h", $time, act, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        #1;
        check(regRdata, exp);
    endtask

    // sync plus decode takes a few cycles, so allow ten before looking
    task automatic step(input logic f, input logic r, input logic run, input logic rev);
        @(posedge ref_clk);
        fwdReq <= f;
        revReq <= r;
        repeat (10) @(posedge ref_clk);
        for (int i = 0; i < 40 && !(runCmd === run && (!run || revCmd === rev)); i++) begin
            @(posedge ref_clk);
        end
        check({30'h0, runCmd, revCmd & run}, {30'h0, run, rev & run});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic resetValues();
        #1;
        check(32'(stationId), 32'h1);
        check(32'(baudSel), 32'h3);
        check(32'(protocolSel), 32'h0);
        check(32'(frameFormat), 32'h0);
        rd(rcs_pkg::ADDR_DELAY, 32'h64);
        rd(rcs_pkg::ADDR_STATION, 32'h1);
        rd(8'hFC, 32'h0);
    endtask

    task automatic refusals();
        wr(rcs_pkg::ADDR_STATION, 32'h0);
        wr(rcs_pkg::ADDR_STATION, 32'hFB);
        rd(rcs_pkg::ADDR_STATION, 32'h1);
        wr(rcs_pkg::ADDR_STATION, 32'hFA);
        check(32'(stationId), 32'hFA);
        wr(rcs_pkg::ADDR_BAUD, 32'h6);
        check(32'(baudSel), 32'h3);
        wr(rcs_pkg::ADDR_BAUD, 32'h0);
        check(32'(baudSel), 32'h0);
        wr(rcs_pkg::ADDR_PROTO, 32'h1);
        check(32'(protocolSel), 32'h1);
        wr(rcs_pkg::ADDR_FRAME, 32'h2);
        check(32'(frameFormat), 32'h2);
        wr(rcs_pkg::ADDR_PROTO, 32'h0);
        wr(rcs_pkg::ADDR_FRAME, 32'h0);
        rd(rcs_pkg::ADDR_FRAME, 32'h0);
        wr(rcs_pkg::ADDR_DELAY, 32'h2711);
        rd(rcs_pkg::ADDR_DELAY, 32'h64);
        wr(rcs_pkg::ADDR_SOURCE, 32'h6);
        rd(rcs_pkg::ADDR_SOURCE, 32'h0);
        for (int i = 0; i < rcs_pkg::NUM_TERM; i++) begin
            wr(rcs_pkg::ADDR_FUNC0 + 8'(4 * i), 32'h0);
        end
        wr(FWD_FN, 32'h1);
        wr(REV_FN, 32'h2);
        wr(FWD_FN, 32'h34);
        rd(FWD_FN, 32'h1);
        rd(REV_FN, 32'h2);
    endtask

    // default delay of 1 s must hold the drive off well past 3000 cycles
    task automatic runOnDelay();
        wr(rcs_pkg::ADDR_SOURCE, 32'h1);
        step(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (3000) @(posedge ref_clk);
        check(32'(runCmd), 32'h0);
        step(1'b0, 1'b0, 1'b0, 1'b0);
        wr(rcs_pkg::ADDR_DELAY, 32'h0);
    endtask

    task automatic twoTerminal();
        step(1'b1, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic runDirection();
        wr(rcs_pkg::ADDR_SOURCE, 32'h2);
        step(1'b1, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b1, 1'b1, 1'b1);
        rd(rcs_pkg::ADDR_STATUS, 32'h823);
        step(1'b0, 1'b1, 1'b0, 1'b0);
        step(1'b1, 1'b0, 1'b1, 1'b0);
    endtask

    // terminals keep asking for forward run throughout
    task automatic serialSource();
        wr(rcs_pkg::ADDR_SOURCE, 32'h3);
        wr(rcs_pkg::ADDR_SERCMD, 32'h0);
        step(1'b1, 1'b0, 1'b0, 1'b0);
        wr(rcs_pkg::ADDR_SERCMD, 32'h3);
        step(1'b1, 1'b0, 1'b1, 1'b1);
        wr(rcs_pkg::ADDR_SERCMD, 32'h1);
        step(1'b1, 1'b0, 1'b1, 1'b0);
        rd(rcs_pkg::ADDR_SERCMD, 32'h1);
        wr(rcs_pkg::ADDR_SOURCE, 32'h0);
        step(1'b1, 1'b0, 1'b0, 1'b0);
        wr(rcs_pkg::ADDR_SOURCE, 32'h5);
        rd(rcs_pkg::ADDR_SOURCE, 32'h5);
        step(1'b1, 1'b0, 1'b0, 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            results();
        end
    end

    initial begin
        nrst      = 1'b0;
        regAddr   = 8'h00;
        regWdata  = 32'h0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        fwdReq    = 1'b0;
        revReq    = 1'b0;
        failCount = 0;
        compares  = 0;
        cycles    = 0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        resetValues();
        refusals();
        runOnDelay();
        twoTerminal();
        runDirection();
        serialSource();
        results();
    end
endmodule // rcs_decoder_test
`default_nettype wire
